/* File: mps_pkg.sv */
// constants, tables and types shared by the motor protection supervisor
// assumes a single 50 MHz core clock and percent-of-set-current inputs
`default_nettype none
package mps_pkg;
  // clock and the millisecond tick that paces every delay
  localparam int CLK_MHZ = 50;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TICK_W = 16;
  // value widths
  localparam int PCT_W = 10;
  localparam int MS_W = 16;
  localparam int SEC_W = 16;
  localparam int OHM_W = 13;
  localparam int CLASS_W = 3;
  // value limits and thresholds
  localparam logic [PCT_W-1:0] LOAD_FULL = 10'h064;
  localparam logic [PCT_W-1:0] QUARTER_PCT = 10'h019;
  localparam logic [PCT_W-1:0] STARTUP_END_PCT = 10'h087;
  localparam logic [7:0] EF_OFF_PCT = 8'hff;
  localparam logic [SEC_W-1:0] TIME_MAX_S = 16'h1999;
  localparam logic [OHM_W-1:0] PTC_MAX_OHM = 13'h12c0;
  localparam logic [MS_W-1:0] NO_DELAY = 16'h0000;
  localparam logic [CLASS_W-1:0] CLASS_LAST = 3'h4;
  // class times for classes 5, 10, 20, 30, 40 in milliseconds
  localparam logic [MS_W-1:0] CLASS_MS [5] =
    '{16'h05dc, 16'h0bb8, 16'h1770, 16'h2328, 16'h2ee0};
  localparam logic [MS_W-1:0] IMB_MS [5] =
    '{16'h07d0, 16'h0dac, 16'h1964, 16'h251c, 16'h30d4};
  // protection function slots
  localparam int NFUNC = 8;
  localparam int F_EOL = 0;
  localparam int F_LR = 1;
  localparam int F_HC = 2;
  localparam int F_LC = 3;
  localparam int F_IMB = 4;
  localparam int F_PL = 5;
  localparam int F_EF = 6;
  localparam int F_PTC = 7;
  // start-up tracker states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_START = 3'b010,
    ST_RUN = 3'b100
  } startup_state_t;
endpackage
`default_nettype wire

/* File: protect_delay.sv */
// persistence timer for one protection condition
// assumes a one-cycle millisecond tick from the same clock
`default_nettype none
`timescale 1ns/1ps
module protect_delay
  import mps_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic cond,
  input wire logic [MS_W-1:0] delay_ms,
  output logic fire
);
  logic [MS_W-1:0] cnt_reg;

  // count held milliseconds, restart whenever the condition drops
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= NO_DELAY;
    else if (!cond)
      cnt_reg <= NO_DELAY;
    else if (tick && cnt_reg < delay_ms)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // zero delay fires in the first cycle of the condition
  assign fire = cond && (cnt_reg >= delay_ms);

  a_fire_needs_cond: assert property (@(posedge core_clk) disable iff (!arst_n)
    fire |-> cond && cnt_reg >= delay_ms && (delay_ms == NO_DELAY || $past(cond)))
    else $error("delayed output without persisting condition");
endmodule
`default_nettype wire

/* File: startup_phase.sv */
// tracks the motor start-up phase after a start command
// assumes start_cmd is a one-cycle pulse and tick a millisecond pulse
`default_nettype none
`timescale 1ns/1ps
module startup_phase
  import mps_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic start_cmd,
  input wire logic motor_running,
  input wire logic [PCT_W-1:0] current_pct,
  input wire logic [CLASS_W-1:0] trip_class,
  output logic in_startup,
  output logic run_phase
);
  startup_state_t state_reg;
  logic [MS_W-1:0] cnt_reg;
  logic seen_high_reg;
  logic [MS_W-1:0] class_ms;
  logic end_now;

  // classes beyond the last one behave as the longest class
  assign class_ms = (trip_class > CLASS_LAST) ? CLASS_MS[CLASS_LAST] : CLASS_MS[trip_class];
  // current must have risen above the end level before it can fall to it
  assign end_now = (seen_high_reg && current_pct <= STARTUP_END_PCT) ||
                   (cnt_reg >= class_ms);

  // phase state
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= ST_IDLE;
    else
    begin
      case (state_reg)
        ST_IDLE: if (start_cmd) state_reg <= ST_START;
        ST_START:
          if (!motor_running && !start_cmd) state_reg <= ST_IDLE;
          else if (end_now) state_reg <= ST_RUN;
        ST_RUN:
          if (start_cmd) state_reg <= ST_START;
          else if (!motor_running) state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // class-time counter, restarted by every start command
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_reg <= NO_DELAY;
    else if (start_cmd)
      cnt_reg <= NO_DELAY;
    else if (state_reg == ST_START && tick && cnt_reg < class_ms)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // remembers that the inrush has been seen
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      seen_high_reg <= 1'b0;
    else if (start_cmd)
      seen_high_reg <= 1'b0;
    else if (current_pct > STARTUP_END_PCT)
      seen_high_reg <= 1'b1;
  end

  assign in_startup = (state_reg == ST_START);
  assign run_phase = (state_reg == ST_RUN);

  a_startup_ends: assert property (@(posedge core_clk) disable iff (!arst_n)
    in_startup && !start_cmd && cnt_reg >= class_ms |=> !in_startup)
    else $error("start-up phase outlived its class time");
endmodule
`default_nettype wire

/* File: motor_protection_supervisor.sv */
// motor protection supervisor: trip and warning decisions with acknowledge
// assumes measured values arrive in core_clk domain; multifunction pins are async
`default_nettype none
`timescale 1ns/1ps
// Contract
// - without auto reset a trip stays until panel, fieldbus or input acknowledge
// - with auto reset a trip clears once its cause has gone
// - auto reset setting is off after reset
// - thermal load reported 0 to 100 percent; 100 percent trips
// - time to trip in seconds, saturating at maximum meaning never
// - time to restart in seconds, same range as time to trip
// - thermal overload always on and always a trip
// - other functions have enable, trip or warning choice, some a delay
// - locked rotor only in start-up; high and low current only after
// - high, low and earth fault have separate warning and trip levels
// - imbalance above quarter current, all phases, delay by trip class
// - imbalance may be off only when phase loss is off too
// - phase loss trip or off, above quarter current, class delay
// - earth fault trip, warning or off; 255 percent level disables it
// - start-up ends at 135 percent current or class time, whichever first
// - start command starts the class-time counter
// - load shedding suppressed while test position is active
// - thermistor resistance reported in ohms up to 4800
// - test position disables checkback and current-related protection
module motor_protection_supervisor
  import mps_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic start_cmd,
  input wire logic motor_running,
  input wire logic [PCT_W-1:0] current_pct,
  input wire logic [2:0] phases_present,
  input wire logic [6:0] imbalance_pct,
  input wire logic [7:0] earth_fault_pct,
  input wire logic [PCT_W-1:0] thermal_load_in,
  input wire logic [SEC_W-1:0] time_to_trip_in,
  input wire logic [SEC_W-1:0] time_to_cool_in,
  input wire logic [OHM_W-1:0] ptc_ohm_in,
  input wire logic [CLASS_W-1:0] trip_class,
  input wire logic autoreset_cfg,
  input wire logic autoreset_wr,
  input wire logic panel_ack,
  input wire logic fieldbus_ack,
  input wire logic [2:0] multifunction_inputs,
  input wire logic [2:0] mfi_ack_sel,
  input wire logic [2:0] mfi_test_sel,
  input wire logic [PCT_W-1:0] prewarn_pct,
  input wire logic lr_en,
  input wire logic [PCT_W-1:0] lr_level,
  input wire logic [MS_W-1:0] lr_delay,
  input wire logic hc_warn_en,
  input wire logic hc_trip_en,
  input wire logic [PCT_W-1:0] hc_warn_level,
  input wire logic [PCT_W-1:0] hc_trip_level,
  input wire logic [MS_W-1:0] hc_warn_delay,
  input wire logic [MS_W-1:0] hc_trip_delay,
  input wire logic lc_warn_en,
  input wire logic lc_trip_en,
  input wire logic [PCT_W-1:0] lc_warn_level,
  input wire logic [PCT_W-1:0] lc_trip_level,
  input wire logic [MS_W-1:0] lc_warn_delay,
  input wire logic [MS_W-1:0] lc_trip_delay,
  input wire logic imb_warn_en,
  input wire logic imb_trip_en,
  input wire logic [6:0] imb_warn_level,
  input wire logic [6:0] imb_trip_level,
  input wire logic pl_en,
  input wire logic ef_warn_en,
  input wire logic ef_trip_en,
  input wire logic [7:0] ef_warn_level,
  input wire logic [7:0] ef_trip_level,
  input wire logic [MS_W-1:0] ef_delay,
  input wire logic ptc_warn_en,
  input wire logic ptc_trip_en,
  input wire logic [OHM_W-1:0] ptc_warn_ohm,
  input wire logic [OHM_W-1:0] ptc_trip_ohm,
  input wire logic load_shed_en,
  output logic [PCT_W-1:0] thermal_load_pct,
  output logic [SEC_W-1:0] time_to_trip_s,
  output logic [SEC_W-1:0] time_to_cool_s,
  output logic [OHM_W-1:0] ptc_ohm,
  output logic [NFUNC-1:0] trip_flags,
  output logic [NFUNC-1:0] warn_flags,
  output logic trip_o,
  output logic warn_o,
  output logic autoreset_on,
  output logic in_startup,
  output logic test_position,
  output logic checkback_active,
  output logic load_shed_active
);
  logic [TICK_W-1:0] tick_cnt_reg;
  logic tick;
  logic [2:0] mfi_s1_reg;
  logic [2:0] mfi_s2_reg;
  logic [2:0] mfi_s3_reg;
  logic ack_any;
  logic test_pos;
  logic act;
  logic run_phase;
  logic autoreset_reg;
  logic imb_sup;
  logic imb_trip_eff;
  logic [MS_W-1:0] class_dly;
  logic [MS_W-1:0] imb_dly;
  logic [NFUNC-1:0] trip_cond;
  logic [NFUNC-1:0] warn_cond;
  logic [NFUNC-1:0] trip_fire;
  logic [NFUNC-1:0] warn_fire;
  logic [NFUNC-1:0] clear_ok;
  logic [NFUNC-1:0] trip_latch_reg;
  logic [NFUNC-1:0] warn_flags_reg;
  logic [MS_W-1:0] trip_dly [NFUNC];
  logic [MS_W-1:0] warn_dly [NFUNC];

  // millisecond tick; the long count is a parameter so simulation can shorten it
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_cnt_reg <= '0;
    else if (tick)
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
  end
  assign tick = (tick_cnt_reg == TICK_W'(TICK_COUNT - 1));

  // multifunction pins: two-stage sync, then a third stage for edges
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mfi_s1_reg <= 3'h0;
      mfi_s2_reg <= 3'h0;
      mfi_s3_reg <= 3'h0;
    end
    else
    begin
      mfi_s1_reg <= multifunction_inputs;
      mfi_s2_reg <= mfi_s1_reg;
      mfi_s3_reg <= mfi_s2_reg;
    end
  end

  // acknowledge sources and test position
  assign ack_any = panel_ack || fieldbus_ack ||
                   |(mfi_s2_reg & ~mfi_s3_reg & mfi_ack_sel);
  assign test_pos = |(mfi_s2_reg & mfi_test_sel);
  assign act = !test_pos;

  // auto reset setting, off out of reset
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      autoreset_reg <= 1'b0;
    else if (autoreset_wr)
      autoreset_reg <= autoreset_cfg;
  end

  startup_phase u_startup (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(tick),
    .start_cmd(start_cmd),
    .motor_running(motor_running),
    .current_pct(current_pct),
    .trip_class(trip_class),
    .in_startup(in_startup),
    .run_phase(run_phase)
  );

  // class-dependent delays, clamped to the longest class
  assign class_dly = (trip_class > CLASS_LAST) ? CLASS_MS[CLASS_LAST] : CLASS_MS[trip_class];
  assign imb_dly = (trip_class > CLASS_LAST) ? IMB_MS[CLASS_LAST] : IMB_MS[trip_class];
  assign imb_sup = act && current_pct > QUARTER_PCT && &phases_present;
  // with phase loss on, an imbalance switched fully off still trips
  assign imb_trip_eff = imb_trip_en || (pl_en && !imb_warn_en);

  // raw conditions per function; current functions drop out in test position
  always_comb
  begin
    trip_cond = '0;
    warn_cond = '0;
    trip_cond[F_EOL] = thermal_load_in >= LOAD_FULL;
    warn_cond[F_EOL] = thermal_load_in >= prewarn_pct;
    trip_cond[F_LR] = act && lr_en && in_startup && current_pct > lr_level;
    trip_cond[F_HC] = act && run_phase && hc_trip_en && current_pct > hc_trip_level;
    warn_cond[F_HC] = act && run_phase && hc_warn_en && current_pct > hc_warn_level;
    trip_cond[F_LC] = act && run_phase && lc_trip_en && current_pct < lc_trip_level;
    warn_cond[F_LC] = act && run_phase && lc_warn_en && current_pct < lc_warn_level;
    trip_cond[F_IMB] = imb_sup && imb_trip_eff && imbalance_pct > imb_trip_level;
    warn_cond[F_IMB] = imb_sup && imb_warn_en && imbalance_pct > imb_warn_level;
    trip_cond[F_PL] = act && pl_en && current_pct > QUARTER_PCT && !(&phases_present);
    trip_cond[F_EF] = act && ef_trip_en && ef_trip_level != EF_OFF_PCT &&
                      earth_fault_pct >= ef_trip_level;
    warn_cond[F_EF] = act && ef_warn_en && ef_warn_level != EF_OFF_PCT &&
                      earth_fault_pct >= ef_warn_level;
    trip_cond[F_PTC] = ptc_trip_en && ptc_ohm_in >= ptc_trip_ohm;
    warn_cond[F_PTC] = ptc_warn_en && ptc_ohm_in >= ptc_warn_ohm;
  end

  // delay per function and kind
  always_comb
  begin
    for (int k = 0; k < NFUNC; k++)
    begin
      trip_dly[k] = NO_DELAY;
      warn_dly[k] = NO_DELAY;
    end
    trip_dly[F_LR] = lr_delay;
    trip_dly[F_HC] = hc_trip_delay;
    warn_dly[F_HC] = hc_warn_delay;
    trip_dly[F_LC] = lc_trip_delay;
    warn_dly[F_LC] = lc_warn_delay;
    trip_dly[F_IMB] = imb_dly;
    warn_dly[F_IMB] = imb_dly;
    trip_dly[F_PL] = class_dly;
    trip_dly[F_EF] = ef_delay;
    warn_dly[F_EF] = ef_delay;
  end

  // overload may only be cleared once the cooling time has run out
  always_comb
  begin
    clear_ok = '1;
    clear_ok[F_EOL] = (time_to_cool_in == '0);
  end

  // one trip timer, one warning timer and one trip latch per function
  for (genvar i = 0; i < NFUNC; i++)
  begin : g_func
    protect_delay u_trip_dly (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .tick(tick),
      .cond(trip_cond[i]),
      .delay_ms(trip_dly[i]),
      .fire(trip_fire[i])
    );
    protect_delay u_warn_dly (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .tick(tick),
      .cond(warn_cond[i]),
      .delay_ms(warn_dly[i]),
      .fire(warn_fire[i])
    );
    // a firing condition wins over any clear in the same cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
      if (!arst_n)
        trip_latch_reg[i] <= 1'b0;
      else if (trip_fire[i])
        trip_latch_reg[i] <= 1'b1;
      else if (clear_ok[i] && autoreset_reg)
        trip_latch_reg[i] <= 1'b0;
      else if (clear_ok[i] && ack_any)
        trip_latch_reg[i] <= 1'b0;
    end
  end

  // warnings follow their conditions, they are not latched
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      warn_flags_reg <= '0;
    else
      warn_flags_reg <= warn_fire;
  end

  // reported values, saturated to their ranges
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      thermal_load_pct <= '0;
      time_to_trip_s <= TIME_MAX_S;
      time_to_cool_s <= '0;
      ptc_ohm <= '0;
    end
    else
    begin
      thermal_load_pct <= (thermal_load_in > LOAD_FULL) ? LOAD_FULL : thermal_load_in;
      time_to_trip_s <= (!motor_running || time_to_trip_in > TIME_MAX_S) ?
                        TIME_MAX_S : time_to_trip_in;
      time_to_cool_s <= (time_to_cool_in > TIME_MAX_S) ? TIME_MAX_S : time_to_cool_in;
      ptc_ohm <= (ptc_ohm_in > PTC_MAX_OHM) ? PTC_MAX_OHM : ptc_ohm_in;
    end
  end

  // test position status, checkback and load shedding gating
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      test_position <= 1'b0;
      checkback_active <= 1'b1;
      load_shed_active <= 1'b0;
    end
    else
    begin
      test_position <= test_pos;
      checkback_active <= !test_pos;
      load_shed_active <= load_shed_en && !test_pos;
    end
  end

  assign trip_flags = trip_latch_reg;
  assign warn_flags = warn_flags_reg;
  assign trip_o = |trip_latch_reg;
  assign warn_o = |warn_flags_reg;
  assign autoreset_on = autoreset_reg;

  a_trip_held: assert property (@(posedge core_clk) disable iff (!arst_n)
    trip_latch_reg[F_HC] && !autoreset_reg && !ack_any |=> trip_latch_reg[F_HC])
    else $error("trip dropped without acknowledge");
  a_auto_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
    autoreset_reg && clear_ok[F_EOL] && !trip_fire[F_EOL] |=> !trip_latch_reg[F_EOL])
    else $error("auto reset failed to clear trip");
  a_autoreset_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    !autoreset_wr |=> autoreset_reg == $past(autoreset_reg))
    else $error("auto reset setting changed without write");
  a_load_range: assert property (@(posedge core_clk) disable iff (!arst_n)
    thermal_load_in >= LOAD_FULL |=> thermal_load_pct == LOAD_FULL && trip_latch_reg[F_EOL])
    else $error("full thermal load not reported or not tripped");
  a_ttt_sat: assert property (@(posedge core_clk) disable iff (!arst_n)
    !motor_running |=> time_to_trip_s == TIME_MAX_S)
    else $error("stopped motor time to trip not at maximum");
  a_cool_range: assert property (@(posedge core_clk) disable iff (!arst_n)
    time_to_cool_s <= TIME_MAX_S)
    else $error("time to restart out of range");
  a_lr_startup: assert property (@(posedge core_clk) disable iff (!arst_n)
    trip_cond[F_LR] |-> in_startup && !run_phase)
    else $error("locked rotor evaluated outside start-up");
  a_ef_off: assert property (@(posedge core_clk) disable iff (!arst_n)
    ef_trip_level == EF_OFF_PCT |-> !trip_cond[F_EF])
    else $error("earth fault active at disabling level");
  a_test_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
    test_pos |=> !load_shed_active && !checkback_active && test_position)
    else $error("test position did not suppress functions");
  a_ptc_range: assert property (@(posedge core_clk) disable iff (!arst_n)
    ptc_ohm <= PTC_MAX_OHM)
    else $error("thermistor value out of range");
  a_agg_warn: assert property (@(posedge core_clk) disable iff (!arst_n)
    |warn_fire |=> warn_o)
    else $error("warning not aggregated");
endmodule
`default_nettype wire

/* File: meas_front.sv */
// behavioural current front end and acknowledging control station
// assumes requests from the bench change just after a core_clk rising edge
`timescale 1ns/1ps
`default_nettype none
module meas_front
  import mps_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic slow,
  input wire logic [PCT_W-1:0] cur_tgt,
  input wire logic [1:0] ack_req,
  input wire logic phase_drop,
  output logic [PCT_W-1:0] current_pct,
  output logic [2:0] phases_present,
  output logic panel_ack,
  output logic fieldbus_ack
);
  // measured current; slow mode ramps up in 16 percent steps like a real inrush, falls straight to a lower target
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
      current_pct <= '0;
    else if (slow && current_pct + 10'h010 < cur_tgt)
      current_pct <= current_pct + 10'h010;
    else
      current_pct <= cur_tgt;

  // acknowledge pulses from panel or fieldbus, one cycle after the request
  always_ff @(posedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      panel_ack <= 1'b0;
      fieldbus_ack <= 1'b0;
    end
    else
    begin
      panel_ack <= ack_req[0];
      fieldbus_ack <= ack_req[1];
    end

  // phase 0 vanishes while the bench asks for a phase loss
  assign phases_present = {2'b11, !phase_drop};
endmodule
`default_nettype wire

/* File: motor_protection_supervisor_tb.sv */
// self-checking bench for the motor protection supervisor
// assumes a short tick (4 cycles a millisecond) so class times stay small
`timescale 1ns/1ps
`default_nettype none
module motor_protection_supervisor_tb
  import mps_pkg::*;
;
  logic core_clk = 1'b0, arst_n = 1'b0, slow, start_cmd, motor_running, autoreset_cfg;
  logic autoreset_wr, lr_en, hc_warn_en, hc_trip_en, lc_warn_en, lc_trip_en, imb_warn_en;
  logic imb_trip_en, pl_en, ef_warn_en, ef_trip_en, ptc_warn_en, ptc_trip_en, load_shed_en;
  logic panel_ack, fieldbus_ack, trip_o, warn_o, autoreset_on, in_startup, test_position;
  logic checkback_active, load_shed_active, phase_drop;
  logic [1:0] ack_req;
  logic [PCT_W-1:0] cur_tgt, current_pct, thermal_load_in, prewarn_pct, lr_level;
  logic [PCT_W-1:0] hc_warn_level, hc_trip_level, lc_warn_level, lc_trip_level, thermal_load_pct;
  logic [MS_W-1:0] lr_delay, hc_warn_delay, hc_trip_delay, lc_warn_delay, lc_trip_delay, ef_delay;
  logic [SEC_W-1:0] time_to_trip_in, time_to_cool_in, time_to_trip_s, time_to_cool_s;
  logic [OHM_W-1:0] ptc_ohm_in, ptc_warn_ohm, ptc_trip_ohm, ptc_ohm;
  logic [2:0] phases_present, multifunction_inputs, mfi_ack_sel, mfi_test_sel;
  logic [CLASS_W-1:0] trip_class;
  logic [6:0] imbalance_pct, imb_warn_level, imb_trip_level;
  logic [7:0] earth_fault_pct, ef_warn_level, ef_trip_level;
  logic [NFUNC-1:0] trip_flags, warn_flags;
  typedef struct {int k; logic [15:0] v;} note_t;
  note_t q[$];
  int error_cnt = 0;
  int n_compared = 0;

  motor_protection_supervisor #(.TICK_COUNT(4)) i_dut (.*);
  meas_front i_front (.*);

  always #10 core_clk = ~core_clk;

  // probe k selects which output group a note refers to
  function automatic logic [15:0] obs(int k);
    case (k)
      0: obs = 16'(trip_flags);
      1: obs = 16'(warn_flags);
      2: obs = 16'(thermal_load_pct);
      3: obs = time_to_trip_s;
      4: obs = time_to_cool_s;
      5: obs = 16'(ptc_ohm);
      default: obs = 16'({trip_o, warn_o, autoreset_on, in_startup, test_position,
                          checkback_active, load_shed_active});
    endcase
  endfunction

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(int k, logic [15:0] v);
    q.push_back('{k, v});
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // bounded wait for an output; running out of patience ends the run
  task automatic till(int k, logic [15:0] v, int lim);
    int i;
    i = 0;
    while (obs(k) !== v && i < lim)
    begin
      @(negedge core_clk);
      i++;
    end
    if (i >= lim)
    begin
      error_cnt++;
      $display("BAD t=%0t wait on probe %0d ran out", $time, k);
      end_of_test();
    end
    else
      chk(k, v);
  endtask

  // watcher: settled outputs compared at the falling edge, oldest note first
  always @(negedge core_clk)
    while (q.size() > 0)
    begin
      note_t n;
      n = q.pop_front();
      n_compared++;
      if (obs(n.k) !== n.v)
      begin
        error_cnt++;
        $display("BAD t=%0t probe %0d got %h want %h", $time, n.k, obs(n.k), n.v);
      end
    end

  // raise the overload trip, then drop the load so only the latch holds it
  task automatic eol_trip();
    @(posedge core_clk);
    thermal_load_in <= LOAD_FULL;
    cyc(3);
    thermal_load_in <= 10'h032;
    cyc(8);
  endtask

  initial
  begin
    void'($urandom(32'h4a92));
    {start_cmd, motor_running, autoreset_cfg, autoreset_wr, load_shed_en, slow, phase_drop} <= '0;
    {lr_en, hc_warn_en, hc_trip_en, lc_warn_en, lc_trip_en, imb_warn_en, imb_trip_en, pl_en,
     ef_warn_en, ef_trip_en, ptc_warn_en, ptc_trip_en} <= '1;
    cur_tgt <= '0;
    ack_req <= '0;
    multifunction_inputs <= '0;
    mfi_ack_sel <= 3'b010;
    mfi_test_sel <= '0;
    trip_class <= '0;
    {thermal_load_in, time_to_trip_in, time_to_cool_in, ptc_ohm_in} <= '0;
    prewarn_pct <= '1;
    lr_level <= 10'h0c8;
    lr_delay <= 16'h0002;
    hc_warn_level <= 10'h078;
    hc_trip_level <= 10'h096;
    hc_warn_delay <= 16'h0003;
    {hc_trip_delay, lc_warn_delay, lc_trip_delay, ef_delay} <= '0;
    {lc_warn_level, lc_trip_level} <= '0;
    imbalance_pct <= 7'($urandom % 10);
    imb_warn_level <= 7'h50;
    imb_trip_level <= 7'h5a;
    {earth_fault_pct, ef_warn_level, ef_trip_level} <= {3{EF_OFF_PCT}};
    {ptc_warn_ohm, ptc_trip_ohm} <= '1;
    cyc(5);
    arst_n <= 1'b1;
    cyc(2);
    chk(3, TIME_MAX_S);
    chk(6, 16'h0002);
    // out-of-range measurements must saturate; the overload trips
    @(posedge core_clk);
    motor_running <= 1'b1;
    thermal_load_in <= 10'h065 + 10'($urandom % 800);
    time_to_trip_in <= 16'h199a + 16'($urandom % 1000);
    time_to_cool_in <= 16'h199a + 16'($urandom % 1000);
    ptc_ohm_in <= 13'h12c1 + 13'($urandom % 2000);
    cyc(3);
    chk(2, 16'(LOAD_FULL));
    chk(3, TIME_MAX_S);
    chk(4, TIME_MAX_S);
    chk(5, 16'(PTC_MAX_OHM));
    chk(0, 16'h0001);
    chk(6, 16'h0042);
    time_to_cool_in <= '0;
    // latched trip cleared by panel, fieldbus and multifunction pin in turn
    for (int s = 0; s < 3; s++)
    begin
      eol_trip();
      chk(0, 16'h0001);
      @(posedge core_clk);
      if (s < 2)
        ack_req <= 2'(1 << s);
      else
        multifunction_inputs[1] <= 1'b1;
      @(posedge core_clk);
      ack_req <= '0;
      cyc(6);
      chk(0, 16'h0000);
      multifunction_inputs <= '0;
    end
    // auto reset: trip clears once its cause is gone, with no acknowledge
    @(posedge core_clk);
    {autoreset_cfg, autoreset_wr} <= 2'b11;
    @(posedge core_clk);
    autoreset_wr <= 1'b0;
    thermal_load_in <= LOAD_FULL;
    cyc(3);
    chk(6, 16'h0052);
    thermal_load_in <= 10'h032;
    cyc(3);
    chk(0, 16'h0000);
    {autoreset_cfg, autoreset_wr} <= 2'b01;
    @(posedge core_clk);
    autoreset_wr <= 1'b0;
    // start with a slow inrush that never falls: class time ends start-up
    @(posedge core_clk);
    {slow, start_cmd} <= 2'b11;
    cur_tgt <= 10'h0fa;
    @(posedge core_clk);
    start_cmd <= 1'b0;
    cyc(2);
    chk(6, 16'h000a);
    cyc(40);
    chk(0, 16'h0002);
    cyc(5800);
    chk(6, 16'h004a);
    till(0, 16'h0006, 400);
    @(posedge core_clk);
    cur_tgt <= 10'h064;
    slow <= 1'b0;
    cyc(3);
    ack_req <= 2'b01;
    @(posedge core_clk);
    ack_req <= '0;
    cyc(4);
    chk(0, 16'h0000);
    // warning delay restarts when the current dips before it expires
    cur_tgt <= 10'h082;
    cyc(7);
    cur_tgt <= 10'h064;
    cyc(4);
    cur_tgt <= 10'h082;
    cyc(7);
    chk(1, 16'h0000);
    cyc(30);
    chk(1, 16'h0004);
    chk(0, 16'h0000);
    // start-up ends early once current falls to 135 percent
    {start_cmd, cur_tgt} <= {1'b1, 10'h0b4};
    @(posedge core_clk);
    start_cmd <= 1'b0;
    cyc(10);
    chk(6, 16'h000a);
    cur_tgt <= STARTUP_END_PCT;
    cyc(4);
    chk(6, 16'h0002);
    cur_tgt <= 10'h064;
    // test position masks earth fault, checkback and load shedding
    mfi_test_sel <= 3'b001;
    multifunction_inputs[0] <= 1'b1;
    load_shed_en <= 1'b1;
    cyc(6);
    ef_trip_level <= 8'h32;
    cyc(6);
    chk(6, 16'h0004);
    multifunction_inputs[0] <= 1'b0;
    cyc(6);
    chk(0, 16'h0040);
    chk(6, 16'h0043);
    // phase loss trips after the class delay; earth fault switched off and cleared
    ef_trip_level <= EF_OFF_PCT;
    phase_drop <= 1'b1;
    ack_req <= 2'b10;
    @(posedge core_clk);
    ack_req <= '0;
    cyc(5900);
    chk(0, 16'h0000);
    till(0, 16'h0020, 400);
    // imbalance uses its own longer delay, here for class 10
    @(posedge core_clk);
    {phase_drop, trip_class} <= {1'b0, 3'h1};
    imbalance_pct <= 7'h5b + 7'($urandom % 9);
    ack_req <= 2'b01;
    @(posedge core_clk);
    ack_req <= '0;
    cyc(13900);
    chk(0, 16'h0000);
    till(1, 16'h0010, 400);
    chk(0, 16'h0010);
    cyc(2);
    end_of_test();
  end
endmodule
`default_nettype wire
